/* File: shared/cps_pkg.sv */
// Shared constants, encodings and carrier structs of the program sequencer.
package cps_pkg;
    localparam int PC_W = 13;
    localparam int BANK_W = 2;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;
    localparam int SP_W = 4;
    localparam int PAGE_LSB = 8;
    localparam logic [SP_W-1:0] STACK_DEPTH = 4'hC;
    localparam logic [SP_W-1:0] STACK_LAST = 4'hB;
    localparam logic [SP_W-1:0] STACK_EMPTY = 4'h0;
    localparam logic [SP_W-1:0] SP_ONE = 4'h1;
    localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
    localparam logic [INSTR_W-1:0] WORD_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        PH_T1 = 2'h0,
        PH_T2 = 2'h1,
        PH_T3 = 2'h2,
        PH_T4 = 2'h3
    } cps_phase_type;

    typedef enum logic [2:0] {
        OP_SEQ = 3'h0,
        OP_JUMP = 3'h1,
        OP_CALL = 3'h2,
        OP_RET = 3'h3,
        OP_INTERRUPT_RETURN = 3'h4,
        OP_SKIPZ = 3'h5,
        OP_SKIPNZ = 3'h6,
        OP_PCLWR = 3'h7
    } cps_op_type;

    typedef enum logic [3:0] {
        ALU_PASS = 4'h0,
        ALU_ADD = 4'h1,
        ALU_ADC = 4'h2,
        ALU_SUB = 4'h3,
        ALU_SBC = 4'h4,
        ALU_AND = 4'h5,
        ALU_OR = 4'h6,
        ALU_XOR = 4'h7,
        ALU_CPL = 4'h8,
        ALU_RR = 4'h9,
        ALU_RRC = 4'hA,
        ALU_RL = 4'hB,
        ALU_RLC = 4'hC,
        ALU_INC = 4'hD,
        ALU_DEC = 4'hE,
        ALU_NONE = 4'hF
    } cps_alu_type;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } cps_status_type;

    typedef struct packed {
        cps_op_type op;
        logic extended;
        cps_alu_type aluOp;
        logic toMem;
        logic [PC_W-1:0] target;
    } cps_ctl_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic strobe;
    } cps_fetch_type;
endpackage

/* File: rtl/cps_alu.sv */
// Eight-bit arithmetic and logic unit with status generation.
`timescale 1ns/1ps
module cps_alu
    import cps_pkg::*;
(
    // Operation select.
    input wire cps_alu_type aluOp,
    // Operands and incoming status.
    input wire logic [DATA_W-1:0] opA,
    input wire logic [DATA_W-1:0] opB,
    input wire cps_status_type statusIn,
    // Result and updated status.
    output logic [DATA_W-1:0] result,
    output cps_status_type statusOut
);
    // Returns {carry, half carry, overflow, sum}.
    function automatic logic [DATA_W+2:0] addf(input logic [DATA_W-1:0] a,
            input logic [DATA_W-1:0] b, input logic cin);
        logic [DATA_W:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        addf = {s[DATA_W], h[4], (a[7] == b[7]) && (s[7] != a[7]), s[DATA_W-1:0]};
    endfunction

    logic [DATA_W+2:0] sum;

    always_comb begin
        sum = {3'h0, BYTE_ZERO};
        result = opB;
        statusOut = statusIn;
        case (aluOp)
            ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
                case (aluOp)
                    ALU_ADD: sum = addf(opA, opB, 1'b0);
                    ALU_ADC: sum = addf(opA, opB, statusIn.c);
                    ALU_SUB: sum = addf(opA, ~opB, 1'b1);
                    default: sum = addf(opA, ~opB, statusIn.c);
                endcase
                result = sum[DATA_W-1:0];
                statusOut.c = sum[DATA_W+2];
                statusOut.ac = sum[DATA_W+1];
                statusOut.ov = sum[DATA_W];
            end
            ALU_AND: result = opA & opB;
            ALU_OR: result = opA | opB;
            ALU_XOR: result = opA ^ opB;
            ALU_CPL: result = ~opB;
            ALU_RR: result = {opB[0], opB[DATA_W-1:1]};
            ALU_RL: result = {opB[DATA_W-2:0], opB[DATA_W-1]};
            ALU_RRC: begin
                result = {statusIn.c, opB[DATA_W-1:1]};
                statusOut.c = opB[0];
            end
            ALU_RLC: begin
                result = {opB[DATA_W-2:0], statusIn.c};
                statusOut.c = opB[DATA_W-1];
            end
            ALU_INC: result = opB + BYTE_ONE;
            ALU_DEC: result = opB - BYTE_ONE;
            default: result = opB;
        endcase
        // Arithmetic, logic, increment and decrement results set the zero flag.
        if (aluOp inside {ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR,
                ALU_XOR, ALU_CPL, ALU_INC, ALU_DEC}) begin
            statusOut.z = (result == BYTE_ZERO);
        end
    end
endmodule

/* File: rtl/cps_return_stack.sv */
// Twelve-level circular return-address stack.
`timescale 1ns/1ps
module cps_return_stack
    import cps_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Push and pop requests, never both at once.
    input wire logic push,
    input wire logic pop,
    input wire logic [PC_W-1:0] pushData,
    // Top entry and fill state.
    output logic [PC_W-1:0] topData,
    output logic full
);
    logic [PC_W-1:0] mem [STACK_DEPTH];
    logic [SP_W-1:0] wrIdx;
    logic [SP_W-1:0] count;
    logic [SP_W-1:0] next_wrIdx;
    logic [SP_W-1:0] next_count;
    logic [SP_W-1:0] rdIdx;

    function automatic logic [SP_W-1:0] wrapDown(input logic [SP_W-1:0] i);
        wrapDown = (i == STACK_EMPTY) ? STACK_LAST : i - SP_ONE;
    endfunction

    always_comb begin
        next_wrIdx = wrIdx;
        next_count = count;
        rdIdx = wrapDown(wrIdx);
        if (push) begin
            next_wrIdx = (wrIdx == STACK_LAST) ? STACK_EMPTY : wrIdx + SP_ONE;
            // A push onto a full stack overwrites the oldest entry.
            if (count != STACK_DEPTH) begin
                next_count = count + SP_ONE;
            end
        end else if (pop && count != STACK_EMPTY) begin
            next_wrIdx = rdIdx;
            next_count = count - SP_ONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wrIdx <= STACK_EMPTY;
            count <= STACK_EMPTY;
        end else begin
            wrIdx <= next_wrIdx;
            count <= next_count;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrIdx] <= pushData;
        end
    end

    assign topData = mem[rdIdx];
    assign full = (count == STACK_DEPTH);

    overflow_keep_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (push && full) |=> (full && topData == $past(pushData)))
        else $error("Push onto full stack lost the new entry.");

    reset_empty_a: assert property (
        @(posedge ref_clk) $past(srst) |-> (count == STACK_EMPTY && wrIdx == STACK_EMPTY))
        else $error("Stack pointer not at top after reset.");
endmodule

/* File: rtl/cps_sequencer.sv */
// Four-phase instruction sequencer with fetch overlap, return stack and ALU.
// Summary of operation
// - Each instruction cycle is four clocks, phases one to four, in fixed order.
// - Phase one fetches a new word and advances the counter; others execute.
// - Fetch overlaps execution; extended instructions hold the pipeline one cycle.
// - Jumps, calls and returns cost one extra cycle as the fetched word is dropped.
// - The counter steps by one unless the instruction branches.
// - Fetch address is bank pointer above the thirteen-bit counter.
// - Only the low counter byte is visible to software, read and write.
// - Writing the low byte jumps within the current page and adds a dummy cycle.
// - Jump, call, interrupt and reset load the counter with their target.
// - A met skip condition drops the fetched word for a dummy cycle.
// - The stack holds counter values only, twelve deep, hidden from software.
// - Call and interrupt acknowledge push; both return kinds pop into the counter.
// - Reset points the stack pointer at the top of the stack.
// - With the stack full an interrupt waits unacknowledged until a return.
// - A call on a full stack proceeds and loses the oldest entry.
// - An eight-bit ALU feeds results to the accumulator or named register.
// - ALU carry, borrow and other status changes update the status register.
// - After reset execution starts at the lowest program address.
`timescale 1ns/1ps
module cps_sequencer
    import cps_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Program memory.
    output cps_fetch_type fetch,
    input wire logic [INSTR_W-1:0] instrWord,
    // Instruction decoder.
    output logic [INSTR_W-1:0] execWord,
    output logic execValid,
    input wire cps_ctl_type ctl,
    // Data memory and special registers.
    input wire logic [BANK_W-1:0] bankPtr,
    input wire logic [DATA_W-1:0] operand,
    output logic [DATA_W-1:0] acc,
    output cps_status_type status,
    output logic memWrite,
    output logic [DATA_W-1:0] memData,
    output logic [DATA_W-1:0] pcLow,
    // Interrupt controller.
    input wire logic intReq,
    input wire logic [PC_W-1:0] intVector,
    output logic intAck,
    output logic intReturn
);
    cps_phase_type phase;
    cps_phase_type next_phase;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] next_pc;
    logic [PC_W-1:0] fetchedAddr;
    logic [PC_W-1:0] next_fetchedAddr;
    cps_fetch_type next_fetch;
    logic fetchIssued;
    logic next_fetchIssued;
    logic [INSTR_W-1:0] fetchReg;
    logic [INSTR_W-1:0] next_fetchReg;
    logic [INSTR_W-1:0] next_execWord;
    logic next_execValid;
    logic extPending;
    logic next_extPending;
    logic next_intAck;
    logic next_intReturn;
    logic [DATA_W-1:0] next_acc;
    cps_status_type next_status;
    logic next_memWrite;
    logic [DATA_W-1:0] next_memData;
    logic [DATA_W-1:0] aluResult;
    cps_status_type aluStatus;
    logic aluZero;
    logic doCommit;
    logic holdExt;
    logic takeInt;
    logic flush;
    logic [PC_W-1:0] branchPc;
    logic stackPush;
    logic stackPop;
    logic [PC_W-1:0] stackIn;
    logic [PC_W-1:0] stackTop;
    logic stackFull;

    cps_alu alu (
        .aluOp(ctl.aluOp),
        .opA(acc),
        .opB(operand),
        .statusIn(status),
        .result(aluResult),
        .statusOut(aluStatus)
    );

    cps_return_stack stack (
        .ref_clk(ref_clk),
        .srst(srst),
        .push(stackPush),
        .pop(stackPop),
        .pushData(stackIn),
        .topData(stackTop),
        .full(stackFull)
    );

    // Phase divider: one clock per phase.
    always_comb begin
        case (phase)
            PH_T1: next_phase = PH_T2;
            PH_T2: next_phase = PH_T3;
            PH_T3: next_phase = PH_T4;
            PH_T4: next_phase = PH_T1;
            default: next_phase = PH_T1;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            phase <= PH_T4;
        end else begin
            phase <= next_phase;
        end
    end

    // Execution decision for the instruction in the execute stage.
    always_comb begin
        aluZero = (aluResult == BYTE_ZERO);
        holdExt = execValid && ctl.extended && !extPending;
        doCommit = (phase == PH_T4) && execValid && !holdExt;
        flush = 1'b0;
        branchPc = pc;
        stackPush = 1'b0;
        stackPop = 1'b0;
        stackIn = fetchedAddr;
        takeInt = 1'b0;
        if (doCommit) begin
            case (ctl.op)
                OP_JUMP: begin
                    flush = 1'b1;
                    branchPc = ctl.target;
                end
                OP_CALL: begin
                    flush = 1'b1;
                    branchPc = ctl.target;
                    stackPush = 1'b1;
                end
                OP_RET, OP_INTERRUPT_RETURN: begin
                    flush = 1'b1;
                    branchPc = stackTop;
                    stackPop = 1'b1;
                end
                OP_SKIPZ: flush = aluZero;
                OP_SKIPNZ: flush = !aluZero;
                OP_PCLWR: begin
                    flush = 1'b1;
                    branchPc = {fetchedAddr[PC_W-1:PAGE_LSB], aluResult};
                end
                default: flush = 1'b0;
            endcase
            // An interrupt takes the slot of the fetched word when the stack has room.
            if (!flush && intReq && !stackFull) begin
                takeInt = 1'b1;
                flush = 1'b1;
                branchPc = intVector;
                stackPush = 1'b1;
            end
        end
    end

    // Fetch and execute pipeline.
    always_comb begin
        next_pc = pc;
        next_fetchedAddr = fetchedAddr;
        next_fetch = fetch;
        next_fetchIssued = fetchIssued;
        next_fetchReg = fetchReg;
        next_execWord = execWord;
        next_execValid = execValid;
        next_extPending = extPending;
        next_intAck = 1'b0;
        next_intReturn = 1'b0;
        next_fetch.strobe = 1'b0;
        // The word fetched during the first half of an extended instruction is kept.
        if (phase == PH_T2 && fetchIssued && !extPending) begin
            next_fetchReg = instrWord;
        end
        if (phase == PH_T4) begin
            if (holdExt) begin
                // Second cycle of an extended instruction: no new fetch.
                next_extPending = 1'b1;
            end else begin
                next_extPending = 1'b0;
                next_fetch.strobe = 1'b1;
                next_fetch.addr = {bankPtr, branchPc};
                next_fetchedAddr = branchPc;
                next_pc = branchPc + PC_ONE;
                next_fetchIssued = 1'b1;
                next_execWord = fetchReg;
                next_execValid = fetchIssued && !flush;
                next_intAck = takeInt;
                next_intReturn = doCommit && ctl.op == OP_INTERRUPT_RETURN;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pc <= RESET_VECTOR;
            fetchedAddr <= RESET_VECTOR;
            fetch <= '0;
            fetchIssued <= 1'b0;
            fetchReg <= WORD_ZERO;
            execWord <= WORD_ZERO;
            execValid <= 1'b0;
            extPending <= 1'b0;
            intAck <= 1'b0;
            intReturn <= 1'b0;
        end else begin
            pc <= next_pc;
            fetchedAddr <= next_fetchedAddr;
            fetch <= next_fetch;
            fetchIssued <= next_fetchIssued;
            fetchReg <= next_fetchReg;
            execWord <= next_execWord;
            execValid <= next_execValid;
            extPending <= next_extPending;
            intAck <= next_intAck;
            intReturn <= next_intReturn;
        end
    end

    // Datapath write-back and status.
    always_comb begin
        next_acc = acc;
        next_status = status;
        next_memWrite = 1'b0;
        next_memData = memData;
        if (doCommit && ctl.aluOp != ALU_NONE) begin
            next_status = aluStatus;
            if (ctl.op inside {OP_SEQ, OP_SKIPZ, OP_SKIPNZ}) begin
                if (ctl.toMem) begin
                    next_memWrite = 1'b1;
                    next_memData = aluResult;
                end else begin
                    next_acc = aluResult;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            acc <= BYTE_ZERO;
            status <= '0;
            memWrite <= 1'b0;
            memData <= BYTE_ZERO;
            pcLow <= BYTE_ZERO;
        end else begin
            acc <= next_acc;
            status <= next_status;
            memWrite <= next_memWrite;
            memData <= next_memData;
            pcLow <= next_fetchedAddr[PAGE_LSB-1:0];
        end
    end

    phase_cycle_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (phase == PH_T1) |=> (phase == PH_T2) ##1 (phase == PH_T3)
            ##1 (phase == PH_T4) ##1 (phase == PH_T1))
        else $error("Phases out of order.");

    fetch_advance_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        fetch.strobe |-> (phase == PH_T1 && pc == fetchedAddr + PC_ONE
            && fetch.addr[PC_W-1:0] == fetchedAddr))
        else $error("Fetch not at phase one or counter not advanced.");

    seq_step_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (doCommit && ctl.op == OP_SEQ && !takeInt)
            |=> (fetch.addr[PC_W-1:0] == $past(pc) && execValid == $past(fetchIssued)))
        else $error("Sequential step did not fetch the next address.");

    jump_dummy_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (doCommit && ctl.op == OP_JUMP)
            |=> (!execValid && fetch.strobe && fetch.addr == {$past(bankPtr), $past(ctl.target)}))
        else $error("Jump did not insert a dummy cycle at its target.");

    pcl_page_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (doCommit && ctl.op == OP_PCLWR) |=> (!execValid
            && fetch.addr[PC_W-1:PAGE_LSB] == $past(fetchedAddr[PC_W-1:PAGE_LSB])
            && fetch.addr[PAGE_LSB-1:0] == $past(aluResult)))
        else $error("Low byte write left its page or kept the fetched word.");

    skip_dummy_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (doCommit && ctl.op == OP_SKIPZ && aluZero) |=> !execValid [*4] ##1 execValid)
        else $error("Taken skip did not give exactly one dummy cycle.");

    ext_hold_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (phase == PH_T4 && holdExt) |=> (!fetch.strobe && extPending && $stable(pc)
            && $stable(execWord)))
        else $error("Extended instruction did not hold the pipeline.");

    full_no_ack_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (phase == PH_T4 && stackFull) |=> !intAck)
        else $error("Interrupt acknowledged with a full stack.");

    ret_restore_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (doCommit && ctl.op == OP_RET) |=> (fetch.addr[PC_W-1:0] == $past(stackTop)))
        else $error("Return did not restore the saved address.");

    reset_vector_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        $past(srst) |=> (fetch.strobe && fetch.addr[PC_W-1:0] == RESET_VECTOR))
        else $error("First fetch after reset not at the reset vector.");
endmodule

/* File: sim/cps_prog_model.sv */
// Program memory, word decoder and interrupt source facing the sequencer.
`timescale 1ns/1ps
module cps_prog_model
    import cps_pkg::*;
(
    // Clock.
    input wire logic ref_clk,
    // Fetch side.
    input wire cps_fetch_type fetch,
    output logic [INSTR_W-1:0] instrWord,
    // Decode side.
    input wire logic [INSTR_W-1:0] execWord,
    output cps_ctl_type ctl,
    // Interrupt side.
    input wire logic raise,
    input wire logic intAck,
    output logic intReq,
    output logic [PC_W-1:0] intVector
);
    logic [INSTR_W-1:0] mem [0:8191];
    logic [INSTR_W-1:0] word = 16'h0000;
    logic ready = 1'b0;
    logic pending = 1'b0;

    // Outside the clock that ends at the sample point the bus shows junk.
    assign instrWord = ready ? word : ~word;
    assign intVector = 13'h1F00;
    assign intReq = pending;

    always @(posedge ref_clk) begin
        ready <= fetch.strobe;
        if (fetch.strobe) begin
            word <= mem[fetch.addr[PC_W-1:0]];
        end
        // A request is held until it is acknowledged.
        if (intAck) begin
            pending <= 1'b0;
        end else if (raise) begin
            pending <= 1'b1;
        end
    end

    always_comb begin
        ctl.op = cps_op_type'(execWord[15:13]);
        ctl.aluOp = cps_alu_type'(execWord[12:9]);
        ctl.extended = execWord[8];
        ctl.toMem = execWord[7];
        ctl.target = {execWord[6:0], 6'h00};
    end
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the program sequencer.
`timescale 1ns/1ps
module testbench
    import cps_pkg::*;
;
    localparam logic [15:0] NOP = 16'h1E00;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [BANK_W-1:0] bankPtr = 2'h0;
    logic [DATA_W-1:0] operand = 8'h00;
    logic raise = 1'b0;
    cps_fetch_type fetch;
    logic [INSTR_W-1:0] instrWord;
    logic [INSTR_W-1:0] execWord;
    logic execValid;
    cps_ctl_type ctl;
    logic [DATA_W-1:0] acc;
    cps_status_type status;
    logic memWrite;
    logic [DATA_W-1:0] memData;
    logic [DATA_W-1:0] pcLow;
    logic intReq;
    logic [PC_W-1:0] intVector;
    logic intAck;
    logic intReturn;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int acks = 0;

    cps_sequencer DUT (.ref_clk(ref_clk), .srst(srst), .fetch(fetch), .instrWord(instrWord),
        .execWord(execWord), .execValid(execValid), .ctl(ctl), .bankPtr(bankPtr),
        .operand(operand), .acc(acc), .status(status), .memWrite(memWrite),
        .memData(memData), .pcLow(pcLow), .intReq(intReq), .intVector(intVector),
        .intAck(intAck), .intReturn(intReturn));
    cps_prog_model PM (.ref_clk(ref_clk), .fetch(fetch), .instrWord(instrWord),
        .execWord(execWord), .ctl(ctl), .raise(raise), .intAck(intAck), .intReq(intReq),
        .intVector(intVector));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] wd(cps_op_type op, cps_alu_type a, logic tm, logic [6:0] t);
        return {op, a, 1'b0, tm, t};
    endfunction

    task automatic fail(input string m);
        errors++;
        $display("mismatch at %0t: %s", $time, m);
    endtask

    task automatic cmp_addr(input logic [ADDR_W-1:0] g, input logic [ADDR_W-1:0] e);
        checks++;
        if (g !== e) fail($sformatf("addr %h want %h", g, e));
    endtask

    task automatic cmp_bit(input logic g, input logic e);
        checks++;
        if (g !== e) fail($sformatf("flag %b want %b", g, e));
    endtask

    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) fail($sformatf("byte %h want %h", g, e));
    endtask

    task automatic cmp_word(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) fail($sformatf("word %h want %h", g, e));
    endtask

    task automatic cmp_stat(input cps_status_type g, input cps_status_type e);
        checks++;
        if (g !== e) fail($sformatf("status %b want %b", g, e));
    endtask

    task automatic cmp_int(input int g, input int e);
        checks++;
        if (g != e) fail($sformatf("count %0d want %0d", g, e));
    endtask

    task automatic next_strobe(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
            if (intAck === 1'b1) acks++;
        end while (fetch.strobe !== 1'b1 && n < 40);
    endtask

    // A gap of zero skips the spacing check.
    task automatic expect_fetch(input logic [ADDR_W-1:0] a, input logic v, input int g);
        int n;
        next_strobe(n);
        cmp_addr(fetch.addr, a);
        cmp_bit(execValid, v);
        if (g != 0) cmp_int(n, g);
    endtask

    task automatic wait_addr(input logic [ADDR_W-1:0] a);
        int n;
        for (int i = 0; i < 60; i++) begin
            next_strobe(n);
            if (fetch.addr === a) return;
        end
        fail("address never fetched");
    endtask

    task automatic do_reset(input logic [BANK_W-1:0] b);
        for (int i = 0; i < 8192; i++) PM.mem[i] = NOP;
        @(posedge ref_clk);
        srst <= 1'b1;
        bankPtr <= b;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
    endtask

    task automatic t_seq();
        do_reset(2'h1);
        PM.mem[3] = NOP | 16'h0100;
        #1;
        cmp_bit(fetch.strobe, 1'b0);
        cmp_byte(acc, 8'h00);
        expect_fetch(15'h2000, 1'b0, 0);
        expect_fetch(15'h2001, 1'b1, 4);
        expect_fetch(15'h2002, 1'b1, 4);
        expect_fetch(15'h2003, 1'b1, 4);
        expect_fetch(15'h2004, 1'b1, 4);
        expect_fetch(15'h2005, 1'b1, 8);
    endtask

    task automatic t_jump();
        do_reset(2'h0);
        PM.mem[0] = wd(OP_JUMP, ALU_NONE, 1'b0, 7'h01);
        expect_fetch(15'h0000, 1'b0, 0);
        expect_fetch(15'h0001, 1'b1, 4);
        expect_fetch(15'h0040, 1'b0, 4);
        expect_fetch(15'h0041, 1'b1, 4);
    endtask

    task automatic t_ret(input cps_op_type op);
        do_reset(2'h0);
        PM.mem[0] = wd(OP_CALL, ALU_NONE, 1'b0, 7'h02);
        PM.mem[128] = wd(op, ALU_NONE, 1'b0, 7'h00);
        expect_fetch(15'h0000, 1'b0, 0);
        expect_fetch(15'h0001, 1'b1, 4);
        expect_fetch(15'h0080, 1'b0, 4);
        expect_fetch(15'h0081, 1'b1, 4);
        cmp_word(execWord, wd(op, ALU_NONE, 1'b0, 7'h00));
        expect_fetch(15'h0001, 1'b0, 4);
        cmp_bit(intReturn, op == OP_INTERRUPT_RETURN);
        expect_fetch(15'h0002, 1'b1, 4);
    endtask

    task automatic t_skip(input cps_op_type op, input logic [7:0] val);
        logic skip;
        skip = (val == 8'h00) == (op == OP_SKIPZ);
        do_reset(2'h0);
        operand <= val;
        PM.mem[0] = wd(op, ALU_PASS, 1'b0, 7'h00);
        expect_fetch(15'h0000, 1'b0, 0);
        expect_fetch(15'h0001, 1'b1, 4);
        expect_fetch(15'h0002, !skip, 4);
        expect_fetch(15'h0003, 1'b1, 4);
    endtask

    task automatic t_pcl();
        do_reset(2'h2);
        operand <= 8'h20;
        PM.mem[0] = wd(OP_JUMP, ALU_NONE, 1'b0, 7'h05);
        PM.mem[320] = wd(OP_PCLWR, ALU_PASS, 1'b0, 7'h00);
        expect_fetch(15'h4000, 1'b0, 0);
        expect_fetch(15'h4001, 1'b1, 4);
        expect_fetch(15'h4140, 1'b0, 4);
        expect_fetch(15'h4141, 1'b1, 4);
        expect_fetch(15'h4120, 1'b0, 4);
        expect_fetch(15'h4121, 1'b1, 4);
        repeat (2) @(posedge ref_clk);
        #1;
        cmp_byte(pcLow, 8'h21);
    endtask

    task automatic t_alu();
        do_reset(2'h0);
        PM.mem[0] = wd(OP_SEQ, ALU_ADD, 1'b0, 7'h00);
        PM.mem[1] = wd(OP_SEQ, ALU_ADD, 1'b0, 7'h00);
        PM.mem[2] = wd(OP_SEQ, ALU_ADD, 1'b1, 7'h00);
        expect_fetch(15'h0000, 1'b0, 0);
        expect_fetch(15'h0001, 1'b1, 4);
        operand <= 8'hFF;
        expect_fetch(15'h0002, 1'b1, 4);
        cmp_byte(acc, 8'hFF);
        cmp_stat(status, 4'h0);
        operand <= 8'h01;
        expect_fetch(15'h0003, 1'b1, 4);
        cmp_byte(acc, 8'h00);
        cmp_stat(status, 4'h7);
        operand <= 8'h05;
        expect_fetch(15'h0004, 1'b1, 4);
        cmp_bit(memWrite, 1'b1);
        cmp_byte(memData, 8'h05);
        cmp_byte(acc, 8'h00);
        cmp_stat(status, 4'h0);
    endtask

    task automatic t_overflow();
        int n;
        do_reset(2'h0);
        for (int k = 0; k < 13; k++) begin
            PM.mem[k * 64] = wd(OP_CALL, ALU_NONE, 1'b0, 7'(k + 1));
            PM.mem[k * 64 + 65] = wd(OP_RET, ALU_NONE, 1'b0, 7'h00);
        end
        wait_addr(15'h0341);
        wait_addr(15'h0041);
        expect_fetch(15'h0042, 1'b1, 4);
        next_strobe(n);
        cmp_bit(fetch.addr == 15'h0001, 1'b0);
    endtask

    task automatic t_stack();
        do_reset(2'h0);
        for (int k = 0; k < 12; k++) PM.mem[k * 64] = wd(OP_CALL, ALU_NONE, 1'b0, 7'(k + 1));
        PM.mem[772] = wd(OP_RET, ALU_NONE, 1'b0, 7'h00);
        raise <= 1'b1;
        acks = 0;
        @(posedge ref_clk);
        raise <= 1'b0;
        wait_addr(15'h0304);
        wait_addr(15'h02C1);
        cmp_int(acks, 0);
        expect_fetch(15'h02C2, 1'b1, 4);
        expect_fetch(15'h1F00, 1'b0, 4);
        cmp_bit(intAck, 1'b1);
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail("timeout");
            end_sim();
        end
    end

    initial begin
        t_seq();
        t_jump();
        t_ret(OP_RET);
        t_ret(OP_INTERRUPT_RETURN);
        t_skip(OP_SKIPZ, 8'h00);
        t_skip(OP_SKIPZ, 8'h05);
        t_skip(OP_SKIPNZ, 8'h00);
        t_skip(OP_SKIPNZ, 8'h05);
        t_pcl();
        t_alu();
        t_overflow();
        t_stack();
        end_sim();
    end
endmodule
